// ===== design/plc_framer_params.svh
`ifndef PLC_FRAMER_PARAMS_SVH
`define PLC_FRAMER_PARAMS_SVH

// timing, in milliseconds, and the clock rate in kHz
`define FR_CLK_KHZ 50000
`define FR_CS_MIN_MS 85
`define FR_CS_MAX_MS 115
`define FR_CS_STEPS 7
`define FR_BUSY_MS 4
`define FR_TIMEOUT_MS 1100
`define FR_ACK_WAIT_MS 500

// framing
`define FR_PREAMBLE 8'hab
`define FR_MAX_PAYLOAD 31
`define FR_CRC8_POLY 8'h07
`define FR_CRC8_INIT 8'h00
`define FR_CRC4_POLY 4'h3
`define FR_CRC4_INIT 4'h0
`define FR_LFSR_SEED 16'hace1
// header tail bytes, counted past the last address byte
`define FR_TAIL_CMD 6'd1
`define FR_TAIL_LEN 6'd2
`define FR_TAIL_SEQ 6'd3
`define FR_LOG_LEN 4'd1
`define FR_EXT_LEN 4'd2
`define FR_GRP_LEN 4'd1
`define FR_PHY_LEN 4'd8
`define FR_NUM_GROUPS 4'd8

// apb byte addresses; the two payload bases are paddr[11:7] values
`define FR_REG_CTRL 12'h000
`define FR_REG_STATUS 12'h004
`define FR_REG_CMD 12'h008
`define FR_REG_THRESH 12'h00c
`define FR_REG_LOGADDR 12'h010
`define FR_REG_GROUP 12'h014
`define FR_REG_PHYS_LO 12'h018
`define FR_REG_PHYS_HI 12'h01c
`define FR_REG_DEST_LO 12'h020
`define FR_REG_DEST_HI 12'h024
`define FR_REG_RXINFO 12'h028
`define FR_REG_RXSRC_LO 12'h02c
`define FR_REG_RXSRC_HI 12'h030
`define FR_PAY_TX_BASE 5'h01
`define FR_PAY_RX_BASE 5'h02

`endif

// ===== design/plc_framer_pkg.sv
package plc_framer_pkg;

  typedef enum logic [1:0] {
    DK_LOGICAL = 2'b00,
    DK_GROUP = 2'b01,
    DK_PHYS = 2'b10,
    DK_INVALID = 2'b11
  } dest_kind_e;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_CSMA = 4'b0010,
    TX_SEND = 4'b0100,
    TX_WAITACK = 4'b1000
  } tx_state_e;

  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_HDR = 4'b0010,
    RX_PAY = 4'b0100,
    RX_CRC = 4'b1000
  } rx_state_e;

  typedef struct packed {
    logic extAddr;
    logic [2:0] retry;
    logic srcKind;
    dest_kind_e dstKind;
    logic service;
    logic start;
  } ctrl_s;

  typedef struct packed {
    logic rxNew;
    logic noAck;
    logic accessFail;
    logic txDone;
  } status_s;

  typedef struct packed {
    logic srcKind;
    dest_kind_e dstKind;
    logic service;
    logic rsvd3;
    logic rsvd2;
    logic response;
    logic rsvd0;
  } flags_s;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } byte_s;

endpackage

// ===== design/powerline_link_layer_framer.sv
// What this block does
// - random carrier-sense window, seven values 85-115 ms
// - transmit only after band free whole window
// - band busy after 4 ms above threshold
// - band busy restarts window with new random delay
// - acquisition timeout abandons attempt, flags failure for data packets, not acks
// - header, 0-31 payload bytes, one CRC byte
// - preamble 0xab sent and expected before header
// - reserved header bits sent as zero
// - flag byte carries address kinds, service, response
// - 4-bit sequence, 4-bit header check, abort mismatch
// - physical addresses 8 bytes, logical one or two bytes
// - final byte CRC-8 over header and payload
// - payload bytes host readable and writable
// - sequence advances per new packet only
// - acked service resends on missing ack, retries
// - unacked service sends retry plus one times
// - duplicates not reported, still acknowledged
// - logical address 8 or 16 bits
// - own 64-bit physical address matches packets
// - single group id and eight membership bits
// - group zero addresses every node
// - group destination forces unacknowledged service
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "plc_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module powerline_link_layer_framer import plc_framer_pkg::*; #(
  parameter int MAX_PAYLOAD = `FR_MAX_PAYLOAD,
  parameter logic [31:0] CS_MIN_CYC = 32'(`FR_CS_MIN_MS * `FR_CLK_KHZ),
  parameter logic [31:0] CS_STEP_CYC =
    32'((`FR_CS_MAX_MS - `FR_CS_MIN_MS) * `FR_CLK_KHZ / (`FR_CS_STEPS - 1)),
  parameter logic [31:0] BUSY_CYC = 32'(`FR_BUSY_MS * `FR_CLK_KHZ),
  parameter logic [31:0] TIMEOUT_CYC = 32'(`FR_TIMEOUT_MS * `FR_CLK_KHZ),
  parameter logic [31:0] ACK_WAIT_CYC = 32'(`FR_ACK_WAIT_MS * `FR_CLK_KHZ),
  // value is arbitrary
  parameter logic [63:0] PHYS_ADDR = 64'h0011_2233_4455_6677
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // modem byte streams
  output var byte_s modemTx,
  input wire logic modemTxReady,
  input wire byte_s modemRx,
  // band occupancy
  input wire logic [7:0] bandLevel,
  output logic bandBusy,
  output logic accessFail
);

  if (MAX_PAYLOAD < 1 || MAX_PAYLOAD > `FR_MAX_PAYLOAD || CS_MIN_CYC == 0 ||
      BUSY_CYC == 0 || TIMEOUT_CYC == 0 || ACK_WAIT_CYC == 0) begin : g_check
    $error("powerline_link_layer_framer: unsupported parameter value");
  end

  function automatic logic [7:0] crc8Byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `FR_CRC8_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [3:0] crc4Byte(input logic [3:0] c, input logic [7:0] d);
    logic [3:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[3] ^ d[i]) ? ({r[2:0], 1'b0} ^ `FR_CRC4_POLY) : {r[2:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [3:0] dstLen(input dest_kind_e k, input logic ext);
    if (k == DK_PHYS) return `FR_PHY_LEN;
    if (k == DK_GROUP) return `FR_GRP_LEN;
    return ext ? `FR_EXT_LEN : `FR_LOG_LEN;
  endfunction

  function automatic logic [3:0] srcLen(input logic phys, input logic ext);
    if (phys) return `FR_PHY_LEN;
    return ext ? `FR_EXT_LEN : `FR_LOG_LEN;
  endfunction

  // most significant byte goes first on the line
  function automatic logic [7:0] addrByte(input logic [63:0] a, input logic [3:0] n,
                                          input logic [3:0] k);
    logic [5:0] sh;
    sh = 6'({n - 4'h1 - k, 3'b000});
    return 8'(a >> sh);
  endfunction

  // registers
  ctrl_s ctrl;
  status_s sts;
  logic startReq;
  logic [7:0] cmdReg;
  logic [4:0] lenReg;
  logic [7:0] thresh;
  logic [15:0] logAddr;
  logic [7:0] singleGroup;
  logic [7:0] groupMask;
  logic [63:0] destAddr;
  logic [7:0] txPay [0:MAX_PAYLOAD-1];
  logic [7:0] rxPay [0:MAX_PAYLOAD-1];

  // tx side state
  tx_state_e state, next_state;
  logic [31:0] toCnt, csCnt, csWin, ackCnt, busyRun;
  logic [15:0] lfsr;
  logic [2:0] retriesLeft;
  logic [3:0] txSeq;
  logic pIsAck, pService, pSrcKind;
  dest_kind_e pDstKind;
  logic [63:0] pDst;
  logic [7:0] pCmd;
  logic [4:0] pLen;
  logic [3:0] pSeq;
  logic [5:0] txIdx;
  logic [7:0] tCrc8;
  logic [3:0] tCrc4;
  logic ackPending;
  logic [63:0] ackDst;
  logic ackPhys;
  logic [3:0] ackSeq;

  // rx side state
  rx_state_e rxState;
  flags_s rFlags;
  logic [5:0] rPos;
  logic [63:0] rDst, rSrc;
  logic [7:0] rCmd;
  logic [4:0] rLen;
  logic [3:0] rSeq;
  logic [7:0] rCrc8;
  logic [3:0] rCrc4;
  logic lastValid;
  logic [63:0] lastSrc;
  logic [3:0] lastSeq;
  logic [7:0] lastCrc;

  // apb decode
  wire logic apbAccess = psel & penable;
  wire logic apbWrite = apbAccess & pready & pwrite;
  wire logic apbCapture = apbAccess & ~pready;
  wire logic [4:0] payIdx = paddr[6:2];
  wire logic payInRange = 32'(payIdx) < MAX_PAYLOAD;
  wire logic isTxPay = (paddr[11:7] == `FR_PAY_TX_BASE) & payInRange;
  wire logic isRxPay = (paddr[11:7] == `FR_PAY_RX_BASE) & payInRange;
  wire logic wrCtrl = apbWrite & (paddr == `FR_REG_CTRL);
  wire logic wrStatus = apbWrite & (paddr == `FR_REG_STATUS);
  logic [31:0] rdMux;
  logic rdHit;

  always_comb begin
    rdHit = 1'b1;
    rdMux = 32'h0;
    if (isTxPay) rdMux = {24'h0, txPay[payIdx]};
    else if (isRxPay) rdMux = {24'h0, rxPay[payIdx]};
    else begin
      unique case (paddr)
        `FR_REG_CTRL: rdMux = {23'h0, ctrl[8:1], 1'b0};
        `FR_REG_STATUS: rdMux = {26'h0, bandBusy, ~(state == TX_IDLE), sts};
        `FR_REG_CMD: rdMux = {19'h0, lenReg, cmdReg};
        `FR_REG_THRESH: rdMux = {24'h0, thresh};
        `FR_REG_LOGADDR: rdMux = {16'h0, logAddr};
        `FR_REG_GROUP: rdMux = {16'h0, groupMask, singleGroup};
        `FR_REG_PHYS_LO: rdMux = PHYS_ADDR[31:0];
        `FR_REG_PHYS_HI: rdMux = PHYS_ADDR[63:32];
        `FR_REG_DEST_LO: rdMux = destAddr[31:0];
        `FR_REG_DEST_HI: rdMux = destAddr[63:32];
        `FR_REG_RXINFO: rdMux = {7'h0, rFlags.srcKind, rCmd, 4'h0, rSeq, 3'h0, rLen};
        `FR_REG_RXSRC_LO: rdMux = rSrc[31:0];
        `FR_REG_RXSRC_HI: rdMux = rSrc[63:32];
        default: rdHit = 1'b0;
      endcase
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbCapture;
      pslverr <= apbCapture & ~rdHit;
      if (apbCapture) prdata <= pwrite ? 32'h0 : rdMux;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= '0;
      cmdReg <= 8'h0;
      lenReg <= 5'h0;
      thresh <= 8'h0;
      logAddr <= 16'h0;
      singleGroup <= 8'h0;
      groupMask <= 8'h0;
      destAddr <= 64'h0;
    end else if (apbWrite) begin
      unique case (paddr)
        `FR_REG_CTRL: ctrl <= ctrl_s'({pwdata[8:1], 1'b0});
        `FR_REG_CMD: {lenReg, cmdReg} <= pwdata[12:0];
        `FR_REG_THRESH: thresh <= pwdata[7:0];
        `FR_REG_LOGADDR: logAddr <= pwdata[15:0];
        `FR_REG_GROUP: {groupMask, singleGroup} <= pwdata[15:0];
        `FR_REG_DEST_LO: destAddr[31:0] <= pwdata;
        `FR_REG_DEST_HI: destAddr[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (apbWrite && isTxPay) txPay[payIdx] <= pwdata[7:0];
  end

  // band occupancy: must persist before the gate closes
  wire logic bandAbove = bandLevel > thresh;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busyRun <= 32'h0;
      bandBusy <= 1'b0;
    end else if (!bandAbove) begin
      busyRun <= 32'h0;
      bandBusy <= 1'b0;
    end else begin
      if (busyRun < BUSY_CYC - 32'h1) busyRun <= busyRun + 32'h1;
      else bandBusy <= 1'b1;
    end
  end

  // random window; code 7 folds onto the middle step
  wire logic [2:0] rnd = (lfsr[2:0] == 3'h7) ? 3'h3 : lfsr[2:0];
  wire logic [31:0] winPick = CS_MIN_CYC + 32'(32'(rnd) * CS_STEP_CYC);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) lfsr <= `FR_LFSR_SEED;
    else lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  // tx byte selection
  wire logic stIdle = state == TX_IDLE;
  wire logic stCsma = state == TX_CSMA;
  wire logic stSend = state == TX_SEND;
  wire logic stWait = state == TX_WAITACK;
  wire logic [63:0] ownSrc = pSrcKind ? PHYS_ADDR : {48'h0, logAddr};
  wire logic [3:0] tdLen = dstLen(pDstKind, ctrl.extAddr);
  wire logic [3:0] tsLen = srcLen(pSrcKind, ctrl.extAddr);
  wire logic [5:0] tAddrEnd = 6'(tdLen) + 6'(tsLen);
  wire logic [5:0] tSeqPos = tAddrEnd + `FR_TAIL_SEQ;
  wire logic [5:0] tCrcPos = tSeqPos + 6'(pLen) + 6'h1;
  wire logic [5:0] tPos = txIdx - 6'h1;
  wire logic [4:0] tPayIdx = 5'(tPos - tSeqPos - 6'h1);
  wire flags_s tFlags = '{srcKind: pSrcKind, dstKind: pDstKind, service: pService,
                          rsvd3: 1'b0, rsvd2: 1'b0, response: pIsAck, rsvd0: 1'b0};
  wire logic [7:0] txCur =
    (txIdx == 6'h0) ? `FR_PREAMBLE :
    (tPos == 6'h0) ? tFlags :
    (tPos <= 6'(tdLen)) ? addrByte(pDst, tdLen, 4'(tPos - 6'h1)) :
    (tPos <= tAddrEnd) ? addrByte(ownSrc, tsLen, 4'(tPos - 6'h1 - 6'(tdLen))) :
    (tPos == tAddrEnd + `FR_TAIL_CMD) ? pCmd :
    (tPos == tAddrEnd + `FR_TAIL_LEN) ? {3'h0, pLen} :
    (tPos == tSeqPos) ? {pSeq, tCrc4} :
    (tPos < tCrcPos) ? txPay[tPayIdx] : tCrc8;
  wire logic txAllOut = (txIdx != 6'h0) && (tPos > tCrcPos);
  wire logic txSlot = ~modemTx.valid | modemTxReady;
  wire logic sendDone = stSend & txAllOut & txSlot;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      modemTx <= '0;
      txIdx <= 6'h0;
      tCrc8 <= `FR_CRC8_INIT;
      tCrc4 <= `FR_CRC4_INIT;
    end else if (!stSend) begin
      modemTx.valid <= 1'b0;
      txIdx <= 6'h0;
      tCrc8 <= `FR_CRC8_INIT;
      tCrc4 <= `FR_CRC4_INIT;
    end else if (txSlot) begin
      if (txAllOut) modemTx.valid <= 1'b0;
      else begin
        modemTx <= '{data: txCur, valid: 1'b1};
        txIdx <= txIdx + 6'h1;
        if (txIdx != 6'h0 && tPos < tCrcPos) tCrc8 <= crc8Byte(tCrc8, txCur);
        if (txIdx != 6'h0 && tPos < tSeqPos) tCrc4 <= crc4Byte(tCrc4, txCur);
      end
    end
  end

  // rx parsing
  wire logic rxByteIn = modemRx.valid;
  wire logic [7:0] rxB = modemRx.data;
  wire flags_s rxB2Flags = flags_s'(rxB);
  wire logic [3:0] rdLen = dstLen(rFlags.dstKind, ctrl.extAddr);
  wire logic [3:0] rsLen = srcLen(rFlags.srcKind, ctrl.extAddr);
  wire logic [5:0] rAddrEnd = 6'(rdLen) + 6'(rsLen);
  wire logic [5:0] rSeqPos = rAddrEnd + `FR_TAIL_SEQ;
  wire logic [4:0] rPayIdx = 5'(rPos - rSeqPos - 6'h1);
  wire logic [5:0] rLastPay = rSeqPos + 6'(rLen);
  wire logic [7:0] rGroup = rDst[7:0];
  wire logic groupBit = (rGroup != 8'h0) && (rGroup <= 8'(`FR_NUM_GROUPS)) &&
                        groupMask[3'(rGroup - 8'h1)];
  wire logic rxForUs =
    (rFlags.dstKind == DK_PHYS) ? (rDst == PHYS_ADDR) :
    (rFlags.dstKind == DK_GROUP) ? ((rGroup == 8'h0) || (rGroup == singleGroup) || groupBit) :
    ctrl.extAddr ? (rDst[15:0] == logAddr) : (rDst[7:0] == logAddr[7:0]);
  wire logic rxEnd = (rxState == RX_CRC) & rxByteIn;
  wire logic rxGood = rxEnd & (rxB == rCrc8) & rxForUs;
  wire logic rxDup = lastValid & (lastSrc == rSrc) & (lastSeq == rSeq) & (lastCrc == rxB);
  wire logic ackSeen = rxGood & rFlags.response & stWait & (rSeq == pSeq);
  wire logic ackReq = rxGood & ~rFlags.response & rFlags.service &
                      (rFlags.dstKind != DK_GROUP);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rxState <= RX_HUNT;
      rPos <= 6'h0;
      rFlags <= '0;
      rDst <= 64'h0;
      rSrc <= 64'h0;
      rCmd <= 8'h0;
      rLen <= 5'h0;
      rSeq <= 4'h0;
      rCrc8 <= `FR_CRC8_INIT;
      rCrc4 <= `FR_CRC4_INIT;
    end else if (rxByteIn) begin
      rPos <= rPos + 6'h1;
      if (rxState != RX_HUNT) rCrc8 <= crc8Byte(rCrc8, rxB);
      unique case (rxState)
        RX_HUNT: if (rxB == `FR_PREAMBLE) begin
          rxState <= RX_HDR;
          rPos <= 6'h0;
          rDst <= 64'h0;
          rSrc <= 64'h0;
          rCrc8 <= `FR_CRC8_INIT;
          rCrc4 <= `FR_CRC4_INIT;
        end
        RX_HDR: begin
          if (rPos < rSeqPos) rCrc4 <= crc4Byte(rCrc4, rxB);
          if (rPos == 6'h0) begin
            rFlags <= rxB2Flags;
            if (rxB2Flags.dstKind == DK_INVALID) rxState <= RX_HUNT;
          end else if (rPos <= 6'(rdLen)) rDst <= {rDst[55:0], rxB};
          else if (rPos <= rAddrEnd) rSrc <= {rSrc[55:0], rxB};
          else if (rPos == rAddrEnd + `FR_TAIL_CMD) rCmd <= rxB;
          else if (rPos == rAddrEnd + `FR_TAIL_LEN) begin
            rLen <= rxB[4:0];
            if (32'(rxB[4:0]) > MAX_PAYLOAD) rxState <= RX_HUNT;
          end else begin
            rSeq <= rxB[7:4];
            if (rxB[3:0] != rCrc4) rxState <= RX_HUNT;
            else rxState <= (rLen == 5'h0) ? RX_CRC : RX_PAY;
          end
        end
        RX_PAY: if (rPos == rLastPay) rxState <= RX_CRC;
        RX_CRC: rxState <= RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rxByteIn && rxState == RX_PAY) rxPay[rPayIdx] <= rxB;
  end

  // duplicate filter and ack queue
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lastValid <= 1'b0;
      lastSrc <= 64'h0;
      lastSeq <= 4'h0;
      lastCrc <= 8'h0;
      ackPending <= 1'b0;
      ackDst <= 64'h0;
      ackPhys <= 1'b0;
      ackSeq <= 4'h0;
    end else begin
      if (rxGood && !rFlags.response) begin
        lastValid <= 1'b1;
        lastSrc <= rSrc;
        lastSeq <= rSeq;
        lastCrc <= rxB;
      end
      if (ackReq) begin
        ackDst <= rSrc;
        ackPhys <= rFlags.srcKind;
        ackSeq <= rSeq;
      end
      // a new request wins over the take
      ackPending <= ackReq | (ackPending & ~(stIdle & next_state == TX_CSMA));
    end
  end

  // channel access and retry sequencing
  wire logic toHit = toCnt >= TIMEOUT_CYC - 32'h1;
  wire logic csHit = csCnt >= csWin - 32'h1;
  wire logic ackHit = ackCnt >= ACK_WAIT_CYC - 32'h1;

  always_comb begin
    next_state = state;
    unique case (state)
      TX_IDLE: if (ackPending || startReq) next_state = TX_CSMA;
      TX_CSMA: begin
        if (toHit) next_state = TX_IDLE;
        else if (!bandBusy && csHit) next_state = TX_SEND;
      end
      TX_SEND: if (sendDone) begin
        if (pIsAck) next_state = TX_IDLE;
        else if (pService) next_state = TX_WAITACK;
        else if (retriesLeft != 3'h0) next_state = TX_CSMA;
        else next_state = TX_IDLE;
      end
      TX_WAITACK: begin
        if (ackSeen) next_state = TX_IDLE;
        else if (ackHit) next_state = (retriesLeft != 3'h0) ? TX_CSMA : TX_IDLE;
      end
    endcase
  end

  wire logic takeAck = stIdle & ackPending;
  wire logic takeData = stIdle & ~ackPending & startReq;
  wire logic retryGo = (stSend | stWait) & (next_state == TX_CSMA);
  wire status_s stsSet = '{
    rxNew: rxGood & ~rFlags.response & ~rxDup,
    noAck: stWait & ~ackSeen & ackHit & (retriesLeft == 3'h0),
    accessFail: stCsma & toHit & ~pIsAck,
    txDone: (sendDone & ~pIsAck & ~pService & (retriesLeft == 3'h0)) | ackSeen};
  wire status_s stsClr = wrStatus ? status_s'(pwdata[3:0]) : '0;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= TX_IDLE;
      sts <= '0;
      accessFail <= 1'b0;
      startReq <= 1'b0;
      toCnt <= 32'h0;
      csCnt <= 32'h0;
      csWin <= CS_MIN_CYC;
      ackCnt <= 32'h0;
    end else begin
      state <= next_state;
      sts <= (sts & ~stsClr) | stsSet;
      accessFail <= (sts.accessFail & ~stsClr.accessFail) | stsSet.accessFail;
      startReq <= (wrCtrl & pwdata[0]) | (startReq & ~takeData);
      toCnt <= stCsma ? toCnt + 32'h1 : 32'h0;
      ackCnt <= stWait ? ackCnt + 32'h1 : 32'h0;
      // busy band restarts the window with a fresh pick
      csCnt <= (stCsma && !bandBusy) ? csCnt + 32'h1 : 32'h0;
      if (!stCsma || bandBusy) csWin <= winPick;
    end
  end

  // packet latch
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pIsAck <= 1'b0;
      pService <= 1'b0;
      pSrcKind <= 1'b0;
      pDstKind <= DK_LOGICAL;
      pDst <= 64'h0;
      pCmd <= 8'h0;
      pLen <= 5'h0;
      pSeq <= 4'h0;
      txSeq <= 4'h0;
      retriesLeft <= 3'h0;
    end else if (takeAck) begin
      pIsAck <= 1'b1;
      pService <= 1'b0;
      pSrcKind <= ctrl.srcKind;
      pDstKind <= ackPhys ? DK_PHYS : DK_LOGICAL;
      pDst <= ackDst;
      pCmd <= 8'h0;
      pLen <= 5'h0;
      pSeq <= ackSeq;
      retriesLeft <= 3'h0;
    end else if (takeData) begin
      pIsAck <= 1'b0;
      pService <= (ctrl.dstKind == DK_GROUP) ? 1'b0 : ctrl.service;
      pSrcKind <= ctrl.srcKind;
      pDstKind <= ctrl.dstKind;
      pDst <= destAddr;
      pCmd <= cmdReg;
      pLen <= (32'(lenReg) > MAX_PAYLOAD) ? 5'(MAX_PAYLOAD) : lenReg;
      pSeq <= txSeq;
      txSeq <= txSeq + 4'h1;
      retriesLeft <= ctrl.retry;
    end else if (retryGo) begin
      retriesLeft <= retriesLeft - 3'h1;
    end
  end

endmodule

`default_nettype wire

// ===== dv/framer_monitor.sv
`include "plc_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module framer_monitor import plc_framer_pkg::*; #(
  parameter logic [31:0] CS_MIN_CYC = 40,
  parameter logic [31:0] BUSY_CYC = 8
) (
  // clock, reset and apb
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // modem and band
  input wire byte_s modemTx,
  input wire logic modemTxReady,
  input wire logic [7:0] bandLevel,
  input wire logic bandBusy,
  input wire logic accessFail
);
  logic [31:0] hiCnt, freeCnt;
  wire stWr = psel && pwrite && paddr == `FR_REG_STATUS;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // run lengths: loud band level, quiet band
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hiCnt <= '0;
      freeCnt <= '0;
    end else begin
      hiCnt <= bandLevel != 8'h00 ? hiCnt + 1 : '0;
      freeCnt <= bandBusy ? '0 : freeCnt + 1;
    end
  end
  a_apb_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("apb answer off");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error reply");
  a_byte_hold: assert property (modemTx.valid && !modemTxReady |=> modemTx.valid && $stable(modemTx.data))
    else $error("byte dropped");
  a_preamble_first: assert property ($rose(modemTx.valid) |-> modemTx.data == `FR_PREAMBLE)
    else $error("no preamble");
  a_quiet_window: assert property ($rose(modemTx.valid) |-> freeCnt >= CS_MIN_CYC)
    else $error("sent into busy band");
  a_busy_persist: assert property ($rose(bandBusy) |-> hiCnt >= BUSY_CYC)
    else $error("busy too soon");
  a_busy_drop: assert property (bandLevel == 8'h00 |=> !bandBusy)
    else $error("busy stuck");
  a_fail_sticky: assert property (accessFail && !stWr && !$past(stWr) |=> accessFail)
    else $error("fail flag lost");
endmodule
bind powerline_link_layer_framer framer_monitor #(.CS_MIN_CYC(CS_MIN_CYC), .BUSY_CYC(BUSY_CYC))
  mon (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .modemTx(modemTx),
  .modemTxReady(modemTxReady), .bandLevel(bandLevel), .bandBusy(bandBusy),
  .accessFail(accessFail));
`default_nettype wire

// ===== dv/modem_peer.sv
`timescale 1ns/1ps
`default_nettype none
module modem_peer import plc_framer_pkg::*; (
  // clock
  input wire logic ref_clk,
  // modem streams
  input wire byte_s modemTx,
  output logic modemTxReady,
  output byte_s modemRx = '{8'h55, 1'b0}
);
  logic [7:0] got[$];
  logic [15:0] sr = 16'h001d;
  // stalls now and then so the sender must hold its byte
  assign modemTxReady = sr[0] | sr[2];
  always @(posedge ref_clk) begin
    sr <= {sr[14:0], sr[15] ^ sr[13]};
    if (modemTx.valid && modemTxReady) got.push_back(modemTx.data);
  end
  // idle data shows the inverse, never a stale byte
  task send(input logic [7:0] b);
    @(posedge ref_clk);
    modemRx <= '{b, 1'b1};
    @(posedge ref_clk);
    modemRx <= '{~b, 1'b0};
  endtask
endmodule
`default_nettype wire

// ===== dv/powerline_link_layer_framer_tb.sv
`include "plc_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module powerline_link_layer_framer_tb import plc_framer_pkg::*; ;
  localparam logic [63:0] PA = 64'h1234_5678_9abc_def0; // value is arbitrary
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, er, bandBusy, accessFail, modemTxReady, sv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rs = 32'd77;
  logic [7:0] bandLevel = 8'h00, my, d, pay[31], exp[$];
  logic [3:0] q = 4'h0;
  logic [2:0] r;
  logic [1:0] dk;
  byte_s modemTx, modemRx;
  int errors = 0, checksDone = 0, cyc = 0, n;
  always #10 ref_clk = ~ref_clk;
  powerline_link_layer_framer #(.CS_MIN_CYC(40), .CS_STEP_CYC(5), .BUSY_CYC(8),
    .TIMEOUT_CYC(2000), .ACK_WAIT_CYC(400), .PHYS_ADDR(PA)) uut (.ref_clk(ref_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modemTx(modemTx), .modemTxReady(modemTxReady), .modemRx(modemRx),
    .bandLevel(bandLevel), .bandBusy(bandBusy), .accessFail(accessFail));
  modem_peer peer (.ref_clk(ref_clk), .modemTx(modemTx), .modemTxReady(modemTxReady),
    .modemRx(modemRx));
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task chk(input logic [31:0] g, e);
    checksDone++;
    if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
    if (g !== e) errors++;
  endtask
  task report_and_stop();
    if (errors == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 40000) errors++;
    if (cyc > 40000) report_and_stop();
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [7:0] crc(logic [7:0] c, b, p, int w);
    for (int i = 7; i >= 0; i--) c = ((c << 1) ^ (c[w-1] ^ b[i] ? p : 8'h00)) & 8'((1 << w) - 1);
    return c;
  endfunction
  task mk(input logic [7:0] f, da, sa, input int len, input logic [3:0] s);
    logic [7:0] h[$];
    logic [7:0] k;
    logic [7:0] c;
    h = '{f, da, sa, f[1] ? 8'h00 : 8'h09, 8'(len)};
    k = 8'h00;
    c = 8'h00;
    foreach (h[i]) k = crc(k, h[i], `FR_CRC4_POLY, 4);
    h.push_back({s, k[3:0]});
    for (int i = 0; i < len; i++) h.push_back(pay[i]);
    foreach (h[i]) c = crc(c, h[i], `FR_CRC8_POLY, 8);
    h.push_back(c);
    h.push_front(`FR_PREAMBLE);
    exp = h;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1;
    apb(0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(0, 12'h01c, 32'h0);
    chk(rd, PA[63:32]);
    apb(0, 12'h3fc, 32'h0);
    chk(er, 1'b1);
    my = 8'(rnd());
    apb(1, 12'h010, {24'h0, my});
    apb(1, 12'h00c, rnd() & 32'h7f);
    for (int i = 0; i < 31; i++) begin
      pay[i] = 8'(rnd());
      apb(1, 12'h080 + 12'(4 * i), {24'h0, pay[i]});
    end
    // unacked, acked without reply, group with service asked
    for (int t = 0; t < 3; t++) begin
      n = rnd() % 32;
      r = t == 1 ? 3'd1 : 3'(rnd() % 3);
      dk = t == 2 ? DK_GROUP : DK_LOGICAL;
      sv = t > 0 && dk != DK_GROUP;
      d = 8'(rnd());
      apb(1, 12'h008, {19'h0, 5'(n), 8'h09});
      apb(1, 12'h020, {24'h0, d});
      apb(1, 12'h000, {24'h0, r, 1'b0, dk, t > 0, 1'b1});
      mk({1'b0, dk, sv, 4'h0}, d, my, n, q);
      rd = 32'h0;
      while (!(rd & (sv ? 32'h4 : 32'h1))) apb(0, 12'h004, 32'h0);
      chk(peer.got.size(), (r + 1) * exp.size());
      foreach (peer.got[i]) chk(peer.got[i], exp[i % exp.size()]);
      peer.got.delete();
      apb(1, 12'h004, 32'hf);
      q++;
    end
    // broadcast frame, then the same frame again
    n = 1 + rnd() % 31;
    mk(8'h20, 8'h00, 8'h5a, n, 4'(rnd()));
    for (int k = 0; k < 2; k++) begin
      foreach (exp[i]) peer.send(exp[i]);
      apb(0, 12'h004, 32'h0);
      chk(rd & 32'h8, k ? 32'h0 : 32'h8);
      apb(0, 12'h100, 32'h0);
      chk(rd, {24'h0, pay[0]});
      apb(1, 12'h004, 32'hf);
    end
    // acked frame to own address draws a reply with no command, no payload
    mk(8'h10, my, 8'h5a, 0, 4'h6);
    foreach (exp[i]) peer.send(exp[i]);
    mk(8'h02, 8'h5a, my, 0, 4'h6);
    repeat (300) @(posedge ref_clk);
    chk(peer.got.size(), exp.size());
    foreach (peer.got[i]) chk(peer.got[i], exp[i]);
    peer.got.delete();
    apb(1, 12'h004, 32'hf);
    bandLevel <= 8'hff;
    repeat (12) @(posedge ref_clk);
    chk(bandBusy, 1'b1);
    apb(1, 12'h000, 32'h1);
    rd = 32'h0;
    while (!(rd & 32'h2)) apb(0, 12'h004, 32'h0);
    chk(accessFail, 1'b1);
    chk(peer.got.size(), 0);
    bandLevel <= 8'h00;
    apb(1, 12'h004, 32'h2);
    apb(0, 12'h004, 32'h0);
    chk(rd & 32'h3f, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
